// >>> shared/pocl_pkg.sv
// Constants and types shared by the power-on configuration loader
package pocl_pkg;
    localparam int unsigned CLK_NS       = 20;
    localparam int unsigned QUIESCE_NS   = 415;
    localparam int unsigned POR_US       = 415;
    localparam int unsigned LOAD_MAX_US  = 320;
    localparam int unsigned SK_HALF_NS   = 500;
    localparam logic [15:0] QUIESCE_CYC  =
        16'((QUIESCE_NS + CLK_NS - 1) / CLK_NS);
    localparam int unsigned POR_CYC      =
        (POR_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned LOAD_MAX_CYC = (LOAD_MAX_US * 1000) / CLK_NS;
    localparam logic [4:0]  SK_HALF_CYC  =
        5'((SK_HALF_NS + CLK_NS - 1) / CLK_NS);

    // Synchronised pin vector layout
    localparam int PIN_W   = 29;
    localparam int PIN_RST = 28;
    localparam int PIN_DO  = 27;
    localparam int PIN_SRC = 26;
    localparam int PIN_WID = 25;
    localparam int PIN_SHM = 24;

    // Configuration register B fields
    localparam int TRIG_BIT  = 5;
    localparam int LINK_BIT  = 6;

    // Reset values of the configuration registers
    localparam logic [7:0] CFG_A_RST = 8'h00;
    localparam logic [7:0] CFG_B_RST = 8'h00;
    localparam logic [7:0] CFG_C_RST = 8'h00;

    // EEPROM word map
    localparam logic [3:0] EE_CFG_LO  = 4'hE;
    localparam logic [3:0] EE_CFG_HI  = 4'hF;
    localparam logic [3:0] EE_SHM_END = 4'h3;
    localparam logic [3:0] EE_IO_END  = 4'h6;
    localparam logic [3:0] EE_ID16    = 4'h7;
    localparam logic [3:0] EE_ID8     = 4'h8;
    localparam logic [7:0] EE_FILL    = 8'h73;

    // Serial command set
    localparam logic [1:0] EE_OP_READ  = 2'h2;
    localparam logic [1:0] EE_OP_WRITE = 2'h1;
    localparam logic [1:0] EE_OP_MISC  = 2'h0;
    localparam logic [5:0] EE_EWEN_A   = 6'h30;
    localparam logic [5:0] EE_EWDS_A   = 6'h00;
    localparam logic [4:0] EE_CMD_BITS  = 5'h09;
    localparam logic [4:0] EE_FULL_BITS = 5'h19;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_LOAD,
        ST_EWEN,
        ST_WRITE,
        ST_POLL,
        ST_EWDS
    } pocl_state_t;
endpackage : pocl_pkg

// >>> logic/pocl_rom_store.sv
// Station address store: eight 16-bit words, byte read port
`timescale 1ns/1ps
module pocl_rom_store
    import pocl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        wr_en_in,
    input  wire logic [2:0]  wr_addr_in,
    input  wire logic [15:0] wr_data_in,
    input  wire logic [3:0]  rd_addr_in,
    output logic      [7:0]  rd_data_out
);
    typedef struct packed {
        logic [7:0][15:0] mem;
        logic [7:0]       rd;
    } pocl_mem_t;

    pocl_mem_t r;
    pocl_mem_t n;

    always_comb begin
        n = r;
        if (wr_en_in) begin
            n.mem[wr_addr_in] = wr_data_in;
        end
        // Odd byte address selects the high byte of the word
        n.rd = rd_addr_in[0] ? r.mem[rd_addr_in[3:1]][15:8]
                             : r.mem[rd_addr_in[3:1]][7:0];
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign rd_data_out = r.rd;
endmodule : pocl_rom_store

// >>> logic/pocl_loader.sv
// Power-on reset qualifier and serial EEPROM configuration loader
`timescale 1ns/1ps
module pocl_loader
    import pocl_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC
)(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        isa_reset_in,
    input  wire logic [23:0] strap_bus_in,
    input  wire logic        cfg_source_pin_in,
    input  wire logic        width_select_pin_in,
    input  wire logic        shared_mode_in,
    input  wire logic        ee_do_in,
    input  wire logic        cfga_wr_in,
    input  wire logic        cfgb_wr_in,
    input  wire logic [7:0]  cfg_wdata_in,
    input  wire logic [3:0]  rom_rd_addr_in,
    output logic             io_quiesce_out,
    output logic             config_latch_window_out,
    output logic             strap_pulldown_out,
    output logic             host_busy_out,
    output logic      [7:0]  cfg_a_out,
    output logic      [7:0]  cfg_b_out,
    output logic      [7:0]  cfg_c_out,
    output logic      [7:0]  rom_rd_data_out,
    output logic             ee_cs_out,
    output logic             ee_sk_out,
    output logic             ee_di_out
);
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] pin;
        logic [15:0]      rst_cnt;
        logic             rst_prev;
        logic             quiesce;
        logic             window;
        logic [7:0]       cfg_a;
        logic [7:0]       cfg_b;
        logic [7:0]       cfg_c;
        logic [7:0]       pa;
        logic [7:0]       pb;
        logic [7:0]       pc;
        logic [1:0]       store_cnt;
        pocl_state_t      st;
        logic [1:0]       step;
        logic [3:0]       addr;
        logic             width16;
        logic             shared;
        logic             cs;
        logic             sk;
        logic [4:0]       div;
        logic [4:0]       nbits;
        logic [24:0]      sh;
        logic [15:0]      rx;
        logic             ser_busy;
        logic             ser_done;
        logic             mem_we;
        logic [2:0]       mem_wa;
        logic [15:0]      mem_wd;
    } pocl_core_t;

    pocl_core_t r;
    pocl_core_t n;

    // Serial command frame, left aligned
    function automatic logic [24:0] ee_cmd(input logic [1:0] op,
                                           input logic [5:0] a,
                                           input logic [15:0] d);
        ee_cmd = {1'b1, op, a, d};
    endfunction : ee_cmd

    // Next word to read; bit 4 set means the load is finished
    function automatic logic [4:0] next_word(input logic [3:0] a,
                                             input logic shm,
                                             input logic w16);
        next_word = 5'h10;
        if (a == EE_CFG_HI) begin
            next_word = {1'b0, EE_CFG_LO};
        end else if (a == EE_CFG_LO) begin
            next_word = 5'h00;
        end else if (shm) begin
            if (a != EE_SHM_END) begin
                next_word = {1'b0, a + 4'h1};
            end
        end else if (a < EE_IO_END) begin
            next_word = {1'b0, a + 4'h1};
        end else if (a == EE_IO_END) begin
            next_word = {1'b0, w16 ? EE_ID16 : EE_ID8};
        end
    endfunction : next_word

    logic host_ok;
    logic [4:0] nxt_word;

    always_comb begin
        n = r;
        n.ser_done = 1'b0;
        n.mem_we   = 1'b0;
        host_ok    = !r.quiesce && r.st == ST_RUN;
        nxt_word   = next_word(r.addr, r.shared, r.width16);

        // Three-stage pin capture; a change counts once stages agree
        n.s1 = {isa_reset_in, ee_do_in, cfg_source_pin_in,
                width_select_pin_in, shared_mode_in, strap_bus_in};
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < PIN_W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.pin[i] = r.s3[i];
            end
        end

        // Serial bit engine; DO sampled before each falling SK edge
        if (r.ser_busy) begin
            if (r.div == SK_HALF_CYC - 5'h01) begin
                n.div = 5'h00;
                n.sk  = !r.sk;
                if (r.sk) begin
                    n.rx    = {r.rx[14:0], r.pin[PIN_DO]};
                    n.sh    = {r.sh[23:0], 1'b0};
                    n.nbits = r.nbits - 5'h01;
                    if (r.nbits == 5'h01) begin
                        n.ser_busy = 1'b0;
                        n.cs       = 1'b0;
                        n.ser_done = 1'b1;
                    end
                end
            end else begin
                n.div = r.div + 5'h01;
            end
        end

        // Sequencer
        case (r.st)
            ST_RUN: begin
                if (host_ok && cfga_wr_in && r.store_cnt == 2'h0) begin
                    n.cfg_a = cfg_wdata_in;
                end
                if (host_ok && cfgb_wr_in) begin
                    case (r.store_cnt)
                        2'h0: begin
                            n.cfg_b = cfg_wdata_in;
                            if (cfg_wdata_in[TRIG_BIT]) begin
                                n.store_cnt = 2'h1;
                            end
                        end
                        2'h1: begin
                            n.pa        = cfg_wdata_in;
                            n.store_cnt = 2'h2;
                        end
                        2'h2: begin
                            n.pb        = cfg_wdata_in;
                            n.store_cnt = 2'h3;
                        end
                        default: begin
                            n.pc   = cfg_wdata_in;
                            n.st   = ST_EWEN;
                            n.step = 2'h0;
                        end
                    endcase
                end
            end
            ST_POLL: begin
                // Drop CS, raise it, then wait for the ready level
                case (r.step)
                    2'h0: begin
                        n.cs   = 1'b0;
                        n.div  = 5'h00;
                        n.step = 2'h1;
                    end
                    2'h1, 2'h2: begin
                        n.div = r.div + 5'h01;
                        if (r.div == SK_HALF_CYC - 5'h01) begin
                            n.div  = 5'h00;
                            n.cs   = 1'b1;
                            n.step = r.step + 2'h1;
                        end
                    end
                    default: begin
                        if (r.pin[PIN_DO]) begin
                            n.cs   = 1'b0;
                            n.step = 2'h0;
                            if (r.addr == EE_CFG_LO) begin
                                n.addr = EE_CFG_HI;
                                n.st   = ST_WRITE;
                            end else begin
                                n.st = ST_EWDS;
                            end
                        end
                    end
                endcase
            end
            default: begin
                // Issue one command, then wait for its last bit
                if (r.step == 2'h0) begin
                    n.cs       = 1'b1;
                    n.sk       = 1'b0;
                    n.div      = 5'h00;
                    n.ser_busy = 1'b1;
                    n.step     = 2'h1;
                    n.nbits    = EE_CMD_BITS;
                    case (r.st)
                        ST_LOAD: begin
                            n.sh    = ee_cmd(EE_OP_READ, {2'b00, r.addr},
                                             16'h0000);
                            n.nbits = EE_FULL_BITS;
                        end
                        ST_EWEN: n.sh = ee_cmd(EE_OP_MISC, EE_EWEN_A,
                                               16'h0000);
                        ST_WRITE: begin
                            n.sh    = ee_cmd(EE_OP_WRITE, {2'b00, r.addr},
                                             (r.addr == EE_CFG_LO) ?
                                             {r.pb, r.pa} :
                                             {EE_FILL, r.pc});
                            n.nbits = EE_FULL_BITS;
                        end
                        default: n.sh = ee_cmd(EE_OP_MISC, EE_EWDS_A,
                                               16'h0000);
                    endcase
                end else if (r.ser_done) begin
                    n.step = 2'h0;
                    case (r.st)
                        ST_LOAD: begin
                            if (r.addr == EE_CFG_HI) begin
                                n.cfg_c = r.rx[7:0];
                            end else if (r.addr == EE_CFG_LO) begin
                                n.cfg_a = r.rx[7:0];
                                n.cfg_b = r.rx[15:8];
                            end else begin
                                // Identifier word lands in the top slot
                                n.mem_we = 1'b1;
                                n.mem_wa = (r.addr > EE_IO_END) ?
                                           3'h7 : r.addr[2:0];
                                n.mem_wd = r.rx;
                            end
                            if (nxt_word[4]) begin
                                n.st = ST_RUN;
                            end else begin
                                n.addr = nxt_word[3:0];
                            end
                        end
                        ST_EWEN: begin
                            n.st   = ST_WRITE;
                            n.addr = EE_CFG_LO;
                        end
                        ST_WRITE: n.st = ST_POLL;
                        default: begin
                            n.st              = ST_RUN;
                            n.store_cnt       = 2'h0;
                            n.cfg_b[TRIG_BIT] = 1'b0;
                        end
                    endcase
                end
            end
        endcase

        // Reset qualification; counter saturates instead of wrapping
        n.rst_prev = r.pin[PIN_RST];
        if (r.pin[PIN_RST]) begin
            if (r.rst_cnt != 16'hFFFF) begin
                n.rst_cnt = r.rst_cnt + 16'h0001;
            end
            if (r.rst_cnt >= QUIESCE_CYC - 16'h0001) begin
                n.quiesce  = 1'b1;
                n.st       = ST_RUN;
                n.step     = 2'h0;
                n.cs       = 1'b0;
                n.sk       = 1'b0;
                n.ser_busy = 1'b0;
                n.sh       = '0; // Data pin must not hang high
                n.store_cnt = 2'h0;
            end
            if (r.rst_cnt >= 16'(POR_CYCLES - 1)) begin
                n.window = 1'b1;
            end
        end else begin
            n.rst_cnt = 16'h0000;
            n.quiesce = 1'b0;
            n.window  = 1'b0;
            if (r.rst_prev && r.window) begin
                n.cfg_a   = r.pin[7:0];
                n.cfg_b   = r.pin[15:8];
                n.cfg_c   = r.pin[23:16];
                n.shared  = r.pin[PIN_SHM];
                n.width16 = r.pin[PIN_WID];
                n.st      = ST_LOAD;
                n.step    = 2'h0;
                n.addr    = r.pin[PIN_SRC] ? EE_CFG_HI : 4'h0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r       <= '0;
            r.st    <= ST_RUN;
            r.cfg_a <= CFG_A_RST;
            r.cfg_b <= CFG_B_RST;
            r.cfg_c <= CFG_C_RST;
        end else begin
            r <= n;
        end
    end

    pocl_rom_store u_store (
        .clk_in      (clk_in),
        .resetn_in   (resetn_in),
        .wr_en_in    (r.mem_we),
        .wr_addr_in  (r.mem_wa),
        .wr_data_in  (r.mem_wd),
        .rd_addr_in  (rom_rd_addr_in),
        .rd_data_out (rom_rd_data_out)
    );

    assign io_quiesce_out          = r.quiesce;
    assign config_latch_window_out = r.window;
    assign strap_pulldown_out      = r.quiesce | r.window;
    assign host_busy_out = r.quiesce | (r.st == ST_LOAD);
    assign cfg_a_out = r.cfg_a;
    assign cfg_b_out = r.cfg_b;
    assign cfg_c_out = r.cfg_c;
    assign ee_cs_out = r.cs;
    assign ee_sk_out = r.sk;
    assign ee_di_out = r.sh[24];
endmodule : pocl_loader

// >>> test/pocl_loader_asserts.sv
// Port checker for the power-on configuration loader
`timescale 1ns/1ps
module pocl_loader_asserts
    import pocl_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC
)(
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        isa_reset_in,
    input  wire logic [23:0] strap_bus_in,
    input  wire logic        cfgb_wr_in,
    input  wire logic [7:0]  cfg_wdata_in,
    input  wire logic        io_quiesce_out,
    input  wire logic        config_latch_window_out,
    input  wire logic        strap_pulldown_out,
    input  wire logic        host_busy_out,
    input  wire logic [7:0]  cfg_a_out,
    input  wire logic [7:0]  cfg_b_out,
    input  wire logic [7:0]  cfg_c_out,
    input  wire logic        ee_cs_out,
    input  wire logic        ee_sk_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic [15:0] rst_len_r;
    logic [15:0] busy_len_r;
    logic [7:0]  sk_len_r;
    logic        sk_q_r;
    // Raw reset length; sync latency only makes the design later
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_len_r  <= 16'h0000;
            busy_len_r <= 16'h0000;
            sk_len_r   <= 8'h00;
            sk_q_r     <= 1'b0;
        end else begin
            rst_len_r  <= isa_reset_in ? rst_len_r + 16'h0001 : 16'h0000;
            busy_len_r <= (host_busy_out && !io_quiesce_out) ?
                          busy_len_r + 16'h0001 : 16'h0000;
            sk_q_r     <= ee_sk_out;
            sk_len_r   <= (ee_sk_out != sk_q_r) ? 8'h00 : sk_len_r + 8'h01;
        end
    end
    property p_quiesce_early;
        $rose(io_quiesce_out) |-> rst_len_r >= QUIESCE_CYC;
    endproperty
    a_quiesce_early: assert property (p_quiesce_early)
        else $error("quiesce raised by a short reset");
    property p_quiesce_late;
        rst_len_r == QUIESCE_CYC + 16'h000A |-> io_quiesce_out;
    endproperty
    a_quiesce_late: assert property (p_quiesce_late)
        else $error("quiesce missing after long reset");
    property p_window_early;
        $rose(config_latch_window_out) |-> rst_len_r >= 16'(POR_CYCLES);
    endproperty
    a_window_early: assert property (p_window_early)
        else $error("latch window too early");
    property p_window_late;
        rst_len_r == 16'(POR_CYCLES + 10) |-> config_latch_window_out;
    endproperty
    a_window_late: assert property (p_window_late)
        else $error("latch window missing");
    property p_pulldown;
        strap_pulldown_out == (io_quiesce_out || config_latch_window_out);
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pull-down state wrong");
    property p_strap_load;
        $fell(config_latch_window_out) |-> ##[0:2]
            (cfg_a_out == strap_bus_in[7:0] && cfg_b_out == strap_bus_in[15:8]
             && cfg_c_out == strap_bus_in[23:16]);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("straps not latched");
    property p_busy_quiesce;
        io_quiesce_out |-> host_busy_out;
    endproperty
    a_busy_quiesce: assert property (p_busy_quiesce)
        else $error("host served during quiesce");
    property p_load_start;
        $fell(config_latch_window_out) |-> ##[0:4] host_busy_out;
    endproperty
    a_load_start: assert property (p_load_start)
        else $error("load did not start");
    property p_load_bound;
        busy_len_r < 16'(LOAD_MAX_CYC);
    endproperty
    a_load_bound: assert property (p_load_bound)
        else $error("load too long");
    property p_sk_half;
        $fell(ee_sk_out) |-> sk_len_r == 8'h18;
    endproperty
    a_sk_half: assert property (p_sk_half)
        else $error("serial clock high time wrong");
    property p_trigger;
        cfgb_wr_in && cfg_wdata_in[TRIG_BIT] && !host_busy_out
            && !cfg_b_out[TRIG_BIT] |=> cfg_b_out[TRIG_BIT];
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("store trigger not taken");
endmodule : pocl_loader_asserts

bind pocl_loader pocl_loader_asserts #(.POR_CYCLES(POR_CYCLES)) u_chk (
    .clk_in, .resetn_in, .isa_reset_in, .strap_bus_in, .cfgb_wr_in,
    .cfg_wdata_in, .io_quiesce_out, .config_latch_window_out,
    .strap_pulldown_out, .host_busy_out, .cfg_a_out, .cfg_b_out,
    .cfg_c_out, .ee_cs_out, .ee_sk_out);

// >>> test/pocl_ee_model.sv
// Serial 16 x 16-bit EEPROM model facing the loader
`timescale 1ns/1ps
module pocl_ee_model (
    input  wire logic        clk_in,
    input  wire logic        ee_cs_in,
    input  wire logic        ee_sk_in,
    input  wire logic        ee_di_in,
    input  wire logic [15:0] busy_len_in,
    output logic             ee_do_out = 1'b0
);
    logic [15:0] mem [0:15];
    logic [24:0] sr = 25'h0000000;
    logic [24:0] sr_nx;
    logic [4:0]  n = 5'h00;
    logic [3:0]  addr = 4'h0;
    logic [15:0] busy = 16'h0000;
    logic        sk_q = 1'b0;
    logic        wr_en = 1'b0;
    logic        rd = 1'b0;
    assign sr_nx = {sr[23:0], ee_di_in};
    always @(posedge clk_in) begin
        sk_q <= ee_sk_in;
        if (busy != 16'h0000)
            busy <= busy - 16'h0001;
        if (!ee_cs_in) begin
            n <= 5'h00;
            rd <= 1'b0;
            ee_do_out <= ~ee_do_out; // Released line has no pull
        end else if (busy != 16'h0000) begin
            ee_do_out <= 1'b0; // Still programming
        end else if (ee_sk_in && !sk_q) begin
            sr <= sr_nx;
            n <= n + 5'h01;
            if (n == 5'h08 && sr_nx[7:6] == 2'b10) begin
                addr <= sr_nx[3:0];
                rd <= 1'b1;
                ee_do_out <= 1'b0;
            end
            if (n == 5'h08 && sr_nx[7:6] == 2'b00)
                wr_en <= sr_nx[5];
            if (rd && n >= 5'h09 && n <= 5'h18)
                ee_do_out <= mem[addr][4'(5'h18 - n)];
            if (n == 5'h18 && sr_nx[23:22] == 2'b01 && wr_en) begin
                mem[sr_nx[19:16]] <= sr_nx[15:0];
                busy <= busy_len_in;
            end
        end else if (n == 5'h00) begin
            ee_do_out <= 1'b1; // Ready status
        end
    end
endmodule : pocl_ee_model

// >>> test/tb.sv
// Self-checking bench for the power-on configuration loader
`timescale 1ns/1ps
module tb;
    import pocl_pkg::*;
    localparam int unsigned PORC = 200;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        isa_rst = 1'b0;
    logic [23:0] strap = 24'h0C110F;
    logic        src = 1'b0;
    logic        wid = 1'b0;
    logic        shm = 1'b0;
    logic        ee_do;
    logic        cfga_wr = 1'b0;
    logic        cfgb_wr = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [3:0]  rd_addr = 4'h0;
    logic        quiesce, window, pull, busy, cs, sk, di, seen;
    logic [7:0]  cfg_a, cfg_b, cfg_c, rom_q;
    logic [15:0] busy_len = 16'h0004;
    logic [7:0]  vals [4];
    int          err_count = 0;
    int          n_tests = 0;

    initial forever #10 clk_in = ~clk_in;

    pocl_loader #(.POR_CYCLES(PORC)) pocl_loader_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .isa_reset_in(isa_rst),
        .strap_bus_in(strap), .cfg_source_pin_in(src),
        .width_select_pin_in(wid), .shared_mode_in(shm), .ee_do_in(ee_do),
        .cfga_wr_in(cfga_wr), .cfgb_wr_in(cfgb_wr), .cfg_wdata_in(wdata),
        .rom_rd_addr_in(rd_addr), .io_quiesce_out(quiesce),
        .config_latch_window_out(window), .strap_pulldown_out(pull),
        .host_busy_out(busy), .cfg_a_out(cfg_a), .cfg_b_out(cfg_b),
        .cfg_c_out(cfg_c), .rom_rd_data_out(rom_q), .ee_cs_out(cs),
        .ee_sk_out(sk), .ee_di_out(di));

    pocl_ee_model pocl_ee_model_inst (
        .clk_in(clk_in), .ee_cs_in(cs), .ee_sk_in(sk), .ee_di_in(di),
        .busy_len_in(busy_len), .ee_do_out(ee_do));

    task automatic report_and_stop();
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc

    // Bounded wait; a stuck engine shows up as a mismatch
    task automatic wait_low(input bit trig);
        int i;
        i = 0;
        while ((trig ? cfg_b[TRIG_BIT] : busy) !== 1'b0 && i < 20000) begin
            cyc(1);
            i++;
        end
        chk(trig ? cfg_b[TRIG_BIT] : busy, 0);
    endtask : wait_low

    task automatic run_por(input logic s, input logic w, input logic m);
        logic [15:0] wd;
        logic [15:0] cw;
        src = s;
        wid = w;
        shm = m;
        isa_rst = 1'b1;
        cyc(PORC + 20);
        chk(window, 1);
        chk(pull, 1);
        isa_rst = 1'b0;
        cyc(8);
        chk(busy, 1);
        cfga_wr = 1'b1;
        wdata = 8'hEE;
        cyc(1);
        cfga_wr = 1'b0;
        wait_low(1'b0);
        cw = pocl_ee_model_inst.mem[14];
        chk(cfg_a, s ? cw[7:0] : strap[7:0]);
        chk(cfg_b, s ? cw[15:8] : strap[15:8]);
        wd = pocl_ee_model_inst.mem[15];
        chk(cfg_c, s ? wd[7:0] : strap[23:16]);
        for (int a = 0; a < (m ? 8 : 16); a++) begin
            rd_addr = 4'(a);
            cyc(2);
            wd = (a >= 14) ? pocl_ee_model_inst.mem[w ? 7 : 8]
                           : pocl_ee_model_inst.mem[a / 2];
            chk(rom_q, a[0] ? wd[15:8] : wd[7:0]);
        end
    endtask : run_por

    initial begin
        for (int i = 0; i < 16; i++)
            pocl_ee_model_inst.mem[i] = 16'(i * 16'h0101);
        pocl_ee_model_inst.mem[0] = 16'h2301;
        pocl_ee_model_inst.mem[1] = 16'h6745;
        pocl_ee_model_inst.mem[2] = 16'hAB89;
        pocl_ee_model_inst.mem[3] = 16'hD310;
        pocl_ee_model_inst.mem[7] = 16'h5757;
        pocl_ee_model_inst.mem[8] = 16'h4242;
        pocl_ee_model_inst.mem[14] = 16'h1A2B;
        pocl_ee_model_inst.mem[15] = 16'h733C;
        cyc(16);
        resetn_in = 1'b1;
        cyc(4);
        chk({cfg_a, cfg_b}, {CFG_A_RST, CFG_B_RST});
        chk(cfg_c, CFG_C_RST);
        // Just under the quiesce threshold
        isa_rst = 1'b1;
        cyc(20);
        isa_rst = 1'b0;
        seen = 1'b0;
        repeat (10) begin
            cyc(1);
            seen = seen | quiesce | busy;
        end
        chk(seen, 0);
        // Long enough to quiesce, too short to load straps
        isa_rst = 1'b1;
        cyc(60);
        chk({quiesce, pull, window}, 3'b110);
        isa_rst = 1'b0;
        cyc(8);
        chk({quiesce, busy, cs}, 3'b000);
        chk(cfg_a, CFG_A_RST);
        run_por(1'b0, 1'b1, 1'b0);
        run_por(1'b1, 1'b0, 1'b0);
        run_por(1'b0, 1'b0, 1'b1);
        run_por(1'b1, 1'b1, 1'b1);
        // Store sequence with a slow part
        busy_len = 16'h0200;
        vals = '{(cfg_b & 8'hBF) | 8'h20, 8'h5D, 8'h02, 8'h6E};
        cfgb_wr = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wdata = vals[i];
            cyc(1);
        end
        cfgb_wr = 1'b0;
        chk(cfg_b[TRIG_BIT], 1);
        wait_low(1'b1);
        chk(pocl_ee_model_inst.mem[14], 16'h025D);
        chk(pocl_ee_model_inst.mem[15], 16'h736E);
        wdata = 8'h77;
        cfga_wr = 1'b1;
        cyc(1);
        cfga_wr = 1'b0;
        cyc(1);
        chk(cfg_a, 8'h77);
        busy_len = 16'h0004;
        run_por(1'b1, 1'b1, 1'b0);
        report_and_stop();
    end

    initial begin
        #(100000 * 20);
        err_count++;
        report_and_stop();
    end
endmodule : tb
